// ### pkg/slas_pkg.sv
// Purpose: Shared constants and types of the supply life alarm sequencer
// Assumes: 10 MHz mclk, timing kept in 1 ms ticks
// Notes:   Display codes name whole three-digit patterns, not segments
package slas_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MS_NS         = 1_000_000;
  localparam int unsigned MS_CYC        = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned MS_W          = 16;

  localparam logic [MS_W-1:0] ALM_ON_MS   = 16'h00c8;  // 200 ms
  localparam logic [MS_W-1:0] ALM_HOLD_MS = 16'h1388;  // 5000 ms
  localparam logic [MS_W-1:0] ALT_MS      = 16'h07d0;  // 2000 ms
  localparam logic [MS_W-1:0] LONG_MS     = 16'h0bb8;  // 3000 ms
  localparam logic [MS_W-1:0] VER_MS      = 16'h01f4;  // 500 ms
  localparam logic [MS_W-1:0] DEB_MS      = 16'h0014;  // 20 ms
  localparam logic [MS_W-1:0] INIT_MS     = 16'h03e8;  // 1000 ms
  localparam logic [MS_W-1:0] PULSE_MS    = 16'h0064;  // 100 ms
  localparam logic [MS_W-1:0] SEC_MS      = 16'h03e8;  // 1000 ms
  localparam logic [MS_W-1:0] HOT_LOCK_S  = 16'h2a30;  // 3 h in seconds
  localparam logic [2:0]      VER_STEPS   = 3'h5;      // show, gap, show, gap, show
  localparam logic [3:0]      FIRST_MONTHS = 4'h1;

  typedef enum logic [2:0] {
    LIFE_FULL = 3'h0,
    LIFE_HALF = 3'h1,
    LIFE_1_5  = 3'h2,
    LIFE_0_5  = 3'h3,
    LIFE_END  = 3'h4
  } slas_life_t;

  typedef enum logic [3:0] {
    DISP_BLANK = 4'h0,
    DISP_INIT  = 4'h1,
    DISP_FULL  = 4'h2,
    DISP_HALF  = 4'h3,
    DISP_1_5   = 4'h4,
    DISP_0_5   = 4'h5,
    DISP_ZERO  = 4'h6,
    DISP_ALARM = 4'h7,
    DISP_VER   = 4'h8,
    DISP_HOT   = 4'h9,
    DISP_ALL   = 4'ha
  } slas_disp_t;

  typedef enum logic [6:0] {
    ST_INIT  = 7'h01,
    ST_RUN   = 7'h02,
    ST_HOT   = 7'h04,
    ST_FAULT = 7'h08,
    ST_DRAIN = 7'h10,
    ST_PDN   = 7'h20,
    ST_OFF   = 7'h40
  } slas_state_t;
endpackage

// ### verilog/slas_sequencer.sv
// Purpose: Sequences the service-life display and alarm output of a supply
// Assumes: sys_rst is applied at power-up; life level and month tick come from
//          the estimator on mclk; button, power-good and run are pins
// Notes:   alarm_out high means ON (conducting)
`timescale 1ns/10ps
module slas_sequencer #(
  parameter int unsigned           TICK_CYC = slas_pkg::MS_CYC,
  parameter logic [slas_pkg::MS_W-1:0] LOCK_S = slas_pkg::HOT_LOCK_S
) (
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire logic                clk_en,
  input  wire logic                test_btn,
  input  wire logic                pwr_ok,
  input  wire logic                ctrl_run,
  input  wire logic                overheat,
  input  wire logic                unit_fault,
  input  wire slas_pkg::slas_life_t life_lvl,
  input  wire logic                month_tick,
  output slas_pkg::slas_disp_t     disp_code,
  output logic                     alarm_out
);
  import slas_pkg::*;
  localparam int unsigned TW = $clog2(TICK_CYC);

  logic [TW-1:0]   tick_reg, tick_next;
  logic            ms_reg, ms_next;
  logic            btn_s1_reg, btn_s2_reg, pwr_s1_reg, pwr_s2_reg, run_s1_reg, run_s2_reg;
  logic            btn_reg, btn_next;
  logic [MS_W-1:0] deb_reg, deb_next;
  logic [MS_W-1:0] press_reg, press_next;
  logic [MS_W-1:0] boot_reg, boot_next;
  logic [MS_W-1:0] sec_reg, sec_next;
  logic [MS_W-1:0] hot_s_reg, hot_s_next;
  logic            lock_reg, lock_next;
  logic            fault_reg, fault_next;
  logic [3:0]      months_reg, months_next;
  logic [MS_W-1:0] alt_reg, alt_next;
  logic            alt_ph_reg, alt_ph_next;
  logic [2:0]      ver_reg, ver_next;
  logic [MS_W-1:0] ver_ms_reg, ver_ms_next;
  slas_state_t     st_reg, st_next;
  logic [MS_W-1:0] ph_reg, ph_next;
  slas_disp_t      disp_reg, disp_next;
  logic            alarm_reg, alarm_next;
  logic            replace, long_hold, boot_on, boot_hold, norm_alarm;
  slas_disp_t      norm_disp;

  function automatic logic [MS_W-1:0] sat_inc(input logic [MS_W-1:0] v, input logic [MS_W-1:0] lim);
    sat_inc = (v >= lim) ? v : v + 16'h0001;
  endfunction

  // Two-flop synchronisers for pin inputs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      btn_s1_reg <= 1'b0;
      btn_s2_reg <= 1'b0;
      pwr_s1_reg <= 1'b1;
      pwr_s2_reg <= 1'b1;
      run_s1_reg <= 1'b0;
      run_s2_reg <= 1'b0;
    end else if (clk_en) begin
      btn_s1_reg <= test_btn;
      btn_s2_reg <= btn_s1_reg;
      pwr_s1_reg <= pwr_ok;
      pwr_s2_reg <= pwr_s1_reg;
      run_s1_reg <= ctrl_run;
      run_s2_reg <= run_s1_reg;
    end
  end

  assign replace    = (life_lvl == LIFE_END) && (months_reg >= FIRST_MONTHS);
  assign long_hold  = btn_reg && (press_reg >= LONG_MS);
  assign boot_on    = boot_reg >= ALM_ON_MS;
  assign boot_hold  = boot_reg < (ALM_ON_MS + ALM_HOLD_MS);
  assign norm_alarm = boot_on && (!replace || boot_hold);

  always_comb begin
    if (months_reg < FIRST_MONTHS) begin
      norm_disp = DISP_FULL;
    end else begin
      case (life_lvl)
        LIFE_FULL: norm_disp = DISP_FULL;
        LIFE_HALF: norm_disp = DISP_HALF;
        LIFE_1_5:  norm_disp = DISP_1_5;
        LIFE_0_5:  norm_disp = DISP_0_5;
        LIFE_END:  norm_disp = alt_ph_reg ? DISP_ALARM : DISP_ZERO;
        default:   norm_disp = DISP_FULL;
      endcase
    end
  end

  // Timebase, debounce, press and life counters
  always_comb begin
    tick_next   = tick_reg + 1'b1;
    ms_next     = 1'b0;
    btn_next    = btn_reg;
    deb_next    = deb_reg;
    press_next  = press_reg;
    boot_next   = boot_reg;
    sec_next    = sec_reg;
    hot_s_next  = hot_s_reg;
    lock_next   = lock_reg;
    fault_next  = fault_reg | unit_fault;
    months_next = months_reg;
    alt_next    = alt_reg;
    alt_ph_next = alt_ph_reg;
    ver_next    = ver_reg;
    ver_ms_next = ver_ms_reg;
    if (tick_reg == TW'(TICK_CYC - 1)) begin
      tick_next = '0;
      ms_next   = 1'b1;
    end
    if (month_tick && months_reg < FIRST_MONTHS) begin
      months_next = months_reg + 4'h1;
    end
    if (ms_reg) begin
      boot_next = sat_inc(boot_reg, ALM_ON_MS + ALM_HOLD_MS);
      if (btn_s2_reg != btn_reg) begin
        deb_next = deb_reg + 16'h0001;
        if (deb_reg >= DEB_MS - 16'h0001) begin
          btn_next = btn_s2_reg;
          deb_next = '0;
        end
      end else begin
        deb_next = '0;
      end
      if (btn_reg) begin
        press_next = sat_inc(press_reg, LONG_MS);
      end
      if (alt_reg >= ALT_MS - 16'h0001) begin
        alt_next    = '0;
        alt_ph_next = !alt_ph_reg;
      end else begin
        alt_next = alt_reg + 16'h0001;
      end
      if (ver_reg != 3'h0) begin
        ver_ms_next = ver_ms_reg + 16'h0001;
        if (ver_ms_reg >= VER_MS - 16'h0001) begin
          ver_ms_next = '0;
          ver_next    = (ver_reg >= VER_STEPS) ? 3'h0 : ver_reg + 3'h1;
        end
      end
      sec_next = (sec_reg >= SEC_MS - 16'h0001) ? '0 : sec_reg + 16'h0001;
      if (!overheat) begin
        hot_s_next = '0;
      end else if (sec_reg >= SEC_MS - 16'h0001) begin
        hot_s_next = sat_inc(hot_s_reg, LOCK_S);
      end
      if (hot_s_reg >= LOCK_S) begin
        lock_next = 1'b1;
      end
    end
    // Short press starts the version display on release
    if (btn_reg && !btn_next) begin
      press_next = '0;
      if (press_reg < LONG_MS && st_reg == ST_RUN) begin
        ver_next    = 3'h1;
        ver_ms_next = '0;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_reg   <= '0;
      ms_reg     <= 1'b0;
      btn_reg    <= 1'b0;
      deb_reg    <= '0;
      press_reg  <= '0;
      boot_reg   <= '0;
      sec_reg    <= '0;
      hot_s_reg  <= '0;
      lock_reg   <= 1'b0;
      fault_reg  <= 1'b0;
      months_reg <= '0;
      alt_reg    <= '0;
      alt_ph_reg <= 1'b0;
      ver_reg    <= '0;
      ver_ms_reg <= '0;
    end else if (clk_en) begin
      tick_reg   <= tick_next;
      ms_reg     <= ms_next;
      btn_reg    <= btn_next;
      deb_reg    <= deb_next;
      press_reg  <= press_next;
      boot_reg   <= boot_next;
      sec_reg    <= sec_next;
      hot_s_reg  <= hot_s_next;
      lock_reg   <= lock_next;
      fault_reg  <= fault_next;
      months_reg <= months_next;
      alt_reg    <= alt_next;
      alt_ph_reg <= alt_ph_next;
      ver_reg    <= ver_next;
      ver_ms_reg <= ver_ms_next;
    end
  end

  // Sequencer and output decode
  always_comb begin
    st_next    = st_reg;
    ph_next    = ms_reg ? sat_inc(ph_reg, INIT_MS) : ph_reg;
    disp_next  = DISP_BLANK;
    alarm_next = 1'b0;
    case (st_reg)
      ST_INIT: begin
        disp_next  = DISP_INIT;
        alarm_next = norm_alarm;
        if (ph_reg >= INIT_MS) begin
          st_next = ST_RUN;
        end
      end
      ST_RUN: begin
        disp_next  = norm_disp;
        alarm_next = norm_alarm;
        if (long_hold) begin
          disp_next  = DISP_ALARM;
          alarm_next = 1'b0;
        end else if (ver_reg != 3'h0) begin
          disp_next = ver_reg[0] ? DISP_VER : DISP_BLANK;
        end
        if (overheat || lock_reg) begin
          st_next = ST_HOT;
        end
      end
      ST_HOT: begin
        disp_next = DISP_HOT;
        if (!overheat && !lock_reg) begin
          st_next = ST_RUN;
        end
      end
      ST_FAULT: begin
        disp_next = DISP_ALL;
      end
      ST_DRAIN: begin
        disp_next  = (lock_reg || overheat) ? DISP_HOT : norm_disp;
        alarm_next = (lock_reg || overheat) ? 1'b0 : norm_alarm;
        if (!run_s2_reg) begin
          st_next = ST_PDN;
          ph_next = '0;
        end
      end
      ST_PDN: begin
        alarm_next = ph_reg < PULSE_MS;
        if (ph_reg >= PULSE_MS) begin
          st_next = ST_OFF;
        end
      end
      ST_OFF: begin
        alarm_next = 1'b0;
      end
      default: begin
        st_next = ST_INIT;
      end
    endcase
    if (fault_reg) begin
      st_next = ST_FAULT;
    end else if (!pwr_s2_reg && (st_reg == ST_INIT || st_reg == ST_RUN || st_reg == ST_HOT)) begin
      st_next = ST_DRAIN;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg    <= ST_INIT;
      ph_reg    <= '0;
      disp_reg  <= DISP_BLANK;
      alarm_reg <= 1'b0;
    end else if (clk_en) begin
      st_reg    <= st_next;
      ph_reg    <= ph_next;
      disp_reg  <= disp_next;
      alarm_reg <= alarm_next;
    end
  end

  assign disp_code = disp_reg;
  assign alarm_out = alarm_reg;

  long_press_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && st_reg == ST_RUN && long_hold) |=> (disp_reg == DISP_ALARM && !alarm_reg))
    else $error("long press did not force alarm code and alarm off");
  release_norm_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && st_reg == ST_RUN && !btn_reg && ver_reg == 3'h0)
    |=> (disp_reg == $past(norm_disp) && alarm_reg == $past(norm_alarm)))
    else $error("normal display or alarm not restored");
  version_show_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && st_reg == ST_RUN && !long_hold && ver_reg != 3'h0)
    |=> (disp_reg == ($past(ver_reg[0]) ? DISP_VER : DISP_BLANK)))
    else $error("version display step wrong");
  end_life_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && st_reg == ST_RUN && replace && !boot_hold && !btn_reg && ver_reg == 3'h0)
    |=> (!alarm_reg && (disp_reg == DISP_ZERO || disp_reg == DISP_ALARM)))
    else $error("end of life display or alarm wrong");
  boot_delay_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && boot_reg < ALM_ON_MS && st_reg != ST_PDN) |=> !alarm_reg)
    else $error("alarm on before startup delay");
  boot_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && st_reg == ST_INIT && boot_on && boot_hold) |=> alarm_reg)
    else $error("alarm not on during startup hold");
  hot_show_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && st_reg == ST_HOT) |=> (disp_reg == DISP_HOT && !alarm_reg))
    else $error("overheat display wrong");
  fault_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && st_reg == ST_FAULT) |=> (st_reg == ST_FAULT && disp_reg == DISP_ALL && !alarm_reg))
    else $error("fault state left or shown wrong");
  hot_lock_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && lock_reg && st_reg == ST_HOT && pwr_s2_reg && !fault_reg) |=> st_reg == ST_HOT)
    else $error("locked overheat state was left");
  pdn_pulse_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && st_reg == ST_PDN && ph_reg < PULSE_MS) |=> (disp_reg == DISP_BLANK && alarm_reg))
    else $error("power-down blank and pulse wrong");
  first_month_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && st_reg == ST_RUN && months_reg < FIRST_MONTHS && !btn_reg && ver_reg == 3'h0)
    |=> disp_reg == DISP_FULL)
    else $error("full life not shown in first month");

  long_press_c: cover property (@(posedge mclk) disable iff (sys_rst) st_reg == ST_RUN && long_hold);
  version_c: cover property (@(posedge mclk) disable iff (sys_rst) ver_reg == VER_STEPS);
  pdn_c: cover property (@(posedge mclk) disable iff (sys_rst) st_reg == ST_OFF);
  lock_c: cover property (@(posedge mclk) disable iff (sys_rst) lock_reg && !overheat);
endmodule // slas_sequencer

// ### tb/slas_partner.sv
// Purpose: Test button and monitoring controller outside the sequencer
// Assumes: Button line idles low; press() is called from the bench
// Notes:   The flag ignores the low alarm of startup until it has been seen ON
`timescale 1ns/10ps
module slas_partner (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic alarm_out,
  output logic      test_btn,
  output logic      notify_flag
);
  logic armed_reg;
  logic armed_next;

  initial test_btn = 1'b0;

  always_comb begin
    armed_next = armed_reg | alarm_out;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= armed_next;
    end
  end

  // Flag set while alarm is off, once alarm has been seen on
  assign notify_flag = armed_reg & ~alarm_out;

  // Holds the button for ms milliseconds of tk cycles each
  task automatic press(input int ms, input int tk);
    @(posedge mclk);
    test_btn <= 1'b1;
    repeat (ms * tk) @(posedge mclk);
    test_btn <= 1'b0;
  endtask
endmodule // slas_partner

// ### tb/tb_supply_life_alarm_sequencer.sv
// Purpose: Self-checking bench of the supply life alarm sequencer
// Assumes: 1 ms shortened to 4 cycles, overheat lock to 2 s
// Notes:   Three power-up runs: normal, replacement due, fault and lock
`timescale 1ns/10ps
module tb_supply_life_alarm_sequencer;
  import slas_pkg::*;
  localparam int TK   = 4;
  localparam int CEIL = 98000;
  logic       mclk, sys_rst, clk_en, pwr_ok, ctrl_run, overheat, unit_fault, month_tick;
  logic       alarm_out, test_btn, notify_flag;
  slas_life_t life_lvl;
  slas_disp_t disp_code, prev;
  int         mismatches, samples_checked, cyc, lv, t1, t2, nver, hold;
  slas_disp_t lv_disp [5] = '{DISP_FULL, DISP_HALF, DISP_1_5, DISP_0_5, DISP_ZERO};
  slas_disp_t seen_q [$];
  slas_disp_t exp_q [$];

  slas_sequencer #(.TICK_CYC(TK), .LOCK_S(16'h0002)) i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .test_btn(test_btn), .pwr_ok(pwr_ok),
    .ctrl_run(ctrl_run), .overheat(overheat), .unit_fault(unit_fault), .life_lvl(life_lvl),
    .month_tick(month_tick), .disp_code(disp_code), .alarm_out(alarm_out));

  slas_partner i_ptr (.mclk(mclk), .sys_rst(sys_rst), .alarm_out(alarm_out), .test_btn(test_btn),
    .notify_flag(notify_flag));

  always #50 mclk = ~mclk;

  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == CEIL) begin
      mismatches = mismatches + 1;
      test_done();
    end
  end

  task automatic test_done();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      mismatches = mismatches + 1;
    end
  endtask

  task automatic look(input slas_disp_t d, input logic a);
    @(negedge mclk);
    chk("disp_code", {28'h0, d}, {28'h0, disp_code});
    chk("alarm_out", {31'h0, a}, {31'h0, alarm_out});
  endtask

  task automatic wait_ms(input int n);
    repeat (n * TK) @(posedge mclk);
  endtask

  task automatic do_reset(input slas_life_t l);
    @(posedge mclk);
    sys_rst  <= 1'b1;
    life_lvl <= l;
    pwr_ok   <= 1'b1;
    ctrl_run <= 1'b1;
    overheat <= 1'b0;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
  endtask

  task automatic power_down(input logic a);
    @(posedge mclk) pwr_ok <= 1'b0;
    wait_ms(50);
    @(negedge mclk) chk("alarm_out", {31'h0, a}, {31'h0, alarm_out});
    chk("disp_blank", 0, {31'h0, disp_code === DISP_BLANK});
    @(posedge mclk) ctrl_run <= 1'b0;
    wait_ms(10);
    look(DISP_BLANK, 1'b1);
    wait_ms(150);
    look(DISP_BLANK, 1'b0);
  endtask

  initial begin
    mclk = 0; sys_rst = 1; clk_en = 1; pwr_ok = 1; ctrl_run = 1; overheat = 0;
    unit_fault = 0; month_tick = 0; life_lvl = LIFE_FULL;
    mismatches = 0; samples_checked = 0; cyc = 0;
    lv = $urandom(32'h0673c1ff);
    lv = 1 + $urandom % 3;
    do_reset(slas_life_t'(lv));
    wait_ms(100);
    look(DISP_INIT, 1'b0);
    chk("notify_flag", 0, {31'h0, notify_flag});
    wait_ms(90);
    look(DISP_INIT, 1'b0);
    wait_ms(20);
    look(DISP_INIT, 1'b1);
    wait_ms(900);
    look(DISP_FULL, 1'b1);
    @(posedge mclk) month_tick <= 1'b1;
    @(posedge mclk) month_tick <= 1'b0;
    wait_ms(5);
    look(lv_disp[lv], 1'b1);
    for (int i = 1; i < 4; i++) begin
      @(posedge mclk) life_lvl <= slas_life_t'(i);
      wait_ms(5);
      look(lv_disp[i], 1'b1);
    end
    // Short press: count version showings and their spacing
    i_ptr.press(50 + $urandom % 950, TK);
    nver = 0;
    prev = disp_code;
    repeat (2800 * TK) begin
      @(negedge mclk);
      if (disp_code === DISP_VER && prev !== DISP_VER) begin
        nver = nver + 1;
        if (nver == 1) t1 = cyc;
        if (nver == 2) t2 = cyc;
      end
      if (disp_code !== prev) seen_q.push_back(disp_code);
      prev = disp_code;
    end
    chk("version_shows", 3, nver);
    chk("version_gap_ms", 1000, (t2 - t1 + TK / 2) / TK);
    // Model of the short-press sequence: three showings with gaps, then the normal code
    exp_q = '{DISP_VER, DISP_BLANK, DISP_VER, DISP_BLANK, DISP_VER, DISP_0_5};
    chk("version_steps", exp_q.size(), seen_q.size());
    for (int k = 0; k < exp_q.size(); k++) begin
      chk("version_seq", {28'h0, exp_q[k]}, (k < seen_q.size()) ? {28'h0, seen_q[k]} : 32'hffff_ffff);
    end
    look(DISP_0_5, 1'b1);
    hold = 3050 + $urandom % 200;
    fork
      i_ptr.press(hold, TK);
      begin
        wait_ms(2900);
        look(DISP_0_5, 1'b1);
        wait_ms(130);
        look(DISP_ALARM, 1'b0);
      end
    join
    wait_ms(40);
    look(DISP_0_5, 1'b1);
    @(posedge mclk) overheat <= 1'b1;
    wait_ms(10);
    look(DISP_HOT, 1'b0);
    @(posedge mclk) overheat <= 1'b0;
    wait_ms(10);
    look(DISP_0_5, 1'b1);
    @(posedge mclk) life_lvl <= LIFE_END;
    wait_ms(5);
    @(negedge mclk) chk("alarm_out", 0, {31'h0, alarm_out});
    chk("notify_flag", 1, {31'h0, notify_flag});
    prev = disp_code;
    for (int n = 0; n < 2; n++) begin
      t2 = cyc;
      while (disp_code === prev && cyc - t2 < 2100 * TK) @(negedge mclk);
      chk("alt_code", (prev === DISP_ZERO) ? DISP_ALARM : DISP_ZERO, {28'h0, disp_code});
      prev = disp_code;
      if (n == 0) t1 = cyc;
      else chk("alt_ms", 2000, (cyc - t1 + TK / 2) / TK);
    end
    @(posedge mclk) life_lvl <= LIFE_0_5;
    wait_ms(5);
    power_down(1'b1);
    // Replacement already due at power-up
    do_reset(LIFE_END);
    @(posedge mclk) month_tick <= 1'b1;
    @(posedge mclk) month_tick <= 1'b0;
    wait_ms(5100);
    @(negedge mclk) chk("alarm_out", 1, {31'h0, alarm_out});
    wait_ms(200);
    @(negedge mclk) chk("alarm_out", 0, {31'h0, alarm_out});
    power_down(1'b0);
    // Long overheat locks, then a fault overrides everything
    do_reset(LIFE_FULL);
    wait_ms(100);
    // Clock enable low must freeze the startup timing
    @(posedge mclk) clk_en <= 1'b0;
    wait_ms(500);
    look(DISP_INIT, 1'b0);
    @(posedge mclk) clk_en <= 1'b1;
    wait_ms(50);
    look(DISP_INIT, 1'b0);
    wait_ms(1100);
    @(posedge mclk) overheat <= 1'b1;
    wait_ms(2500);
    look(DISP_HOT, 1'b0);
    @(posedge mclk) overheat <= 1'b0;
    wait_ms(20);
    look(DISP_HOT, 1'b0);
    @(posedge mclk) unit_fault <= 1'b1;
    @(posedge mclk) unit_fault <= 1'b0;
    wait_ms(5);
    look(DISP_ALL, 1'b0);
    @(posedge mclk) pwr_ok <= 1'b0;
    wait_ms(20);
    look(DISP_ALL, 1'b0);
    test_done();
  end
endmodule // tb_supply_life_alarm_sequencer
